/* hw/irq_unit_regs.vh */
// Register map, field positions and reset values of the interrupt request unit.
`ifndef IRQ_UNIT_REGS_VH
`define IRQ_UNIT_REGS_VH

// ********************************************************************
// Register offsets and reset values
// ********************************************************************
`define ADDR_W 8
`define FLAGS_LOW_ADDR 8'h06
`define FLAGS_HIGH_ADDR 8'h07
`define ENABLE_LOW_ADDR 8'h08
`define ENABLE_HIGH_ADDR 8'h09
`define FLAGS_LOW_RESET 7'h00
`define FLAGS_HIGH_RESET 6'h00
`define ENABLE_RESET 8'h00
`define READ_ZERO 8'h00

// ********************************************************************
// Field positions
// ********************************************************************
`define SET_BIT 7
`define FLAG_LOW_W 7
`define FLAG_HIGH_W 6
`define FIFO_HIGH_BIT 6
`define FIFO_LOW_BIT 5
`define CMD_DONE_BIT 4
`define TX_DONE_BIT 3
`define RX_DONE_BIT 2
`define ERR_SUM_BIT 1
`define FRAME_START_BIT 0
`define COMBINED_BIT 6
`define CARD_BIT 5
`define PIN_INVERT_BIT 7
`define PIN_ENABLE_BIT 6
`define PUSH_PULL_BIT 7
`define TIMER_E_BIT 4
`define TIMER_D_BIT 3
`define TIMER_C_BIT 2
`define TIMER_B_BIT 1
`define TIMER_A_BIT 0

// ********************************************************************
// FIFO level and command constants
// ********************************************************************
`define FIFO_CNT_W 10
`define FIFO_SIZE_SMALL 10'h0FF
`define FIFO_SIZE_LARGE 10'h200
`define CMD_W 5
`define CMD_IDLE 5'h00

`endif

/* hw/flag_bank.v */
// Bank of sticky event flags with bulk set or clear by a written mask.
`timescale 1ns/1ns
module flag_bank #(
  parameter WIDTH = 7,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire clk_sys,
  input wire rst_b,
  input wire [WIDTH-1:0] evt_level,
  input wire wr_stb,
  input wire wr_set,
  input wire [WIDTH-1:0] wr_mask,
  output wire [WIDTH-1:0] flags
);

  reg [WIDTH-1:0] prev_r;
  reg [WIDTH-1:0] flags_r;

  assign flags = flags_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
      wire rise;
      assign rise = evt_level[i] & ~prev_r[i];
      always @(posedge clk_sys) begin
        if (!rst_b) begin
          prev_r[i] <= 1'b0;
          flags_r[i] <= RESET_VAL[i];
        // A rising event beats a clear written in the same cycle.
        end else begin
          prev_r[i] <= evt_level[i];
          if (rise) begin
            flags_r[i] <= 1'b1;
          end else if (wr_stb && wr_mask[i]) begin
            flags_r[i] <= wr_set;
          end
        end
      end
    end
  endgenerate

endmodule // flag_bank

/* hw/irq_pin_driver.v */
// Interrupt pin driver with gating, polarity and drive mode selection.
`timescale 1ns/1ns
module irq_pin_driver (
  input wire clk_sys,
  input wire rst_b,
  input wire request,
  input wire pin_request_enable,
  input wire pin_invert,
  input wire pin_drive_push_pull,
  output wire irq_pin_out,
  output wire irq_pin_oe_b
);

  reg out_r;
  reg oe_b_r;
  wire level;

  assign level = (request & pin_request_enable) ^ pin_invert;

  assign irq_pin_out = out_r;
  assign irq_pin_oe_b = oe_b_r;

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      out_r <= 1'b0;
      oe_b_r <= 1'b0;
    end else begin
      if (pin_drive_push_pull) begin
        out_r <= level;
        oe_b_r <= 1'b0;
      end else begin
        // Open drain only ever pulls low; a high level is left to the pull-up.
        out_r <= 1'b0;
        oe_b_r <= level;
      end
    end
  end

endmodule // irq_pin_driver

/* hw/reader_interrupt_request_unit.v */
// Interrupt request unit: event flags, enables, combined request and pin.
`timescale 1ns/1ns
`include "irq_unit_regs.vh"
module reader_interrupt_request_unit #(
  parameter [31:0] CMD_KNOWN_MASK = 32'h00FF_FFFF
) (
  input wire clk_sys,
  input wire rst_b,

  // Register port of the host interface.
  input wire [7:0] reg_addr,
  input wire reg_wr_en,
  input wire [7:0] reg_wdata,
  input wire reg_rd_en,
  output wire [7:0] reg_rdata,
  output wire reg_hit,

  // FIFO level monitor.
  input wire fifo_size_small,
  input wire [9:0] fifo_length,
  input wire [8:0] water_level,

  // Command sequencer.
  input wire command_finished,
  input wire command_start,
  input wire [4:0] command_start_code,
  output wire command_force_idle,

  // Transmitter, receiver and error logic.
  input wire transmit_last_bit,
  input wire receive_end,
  input wire frame_start_seen,
  input wire fifo_write_violation,
  input wire fifo_overflow_error,
  input wire protocol_error,
  input wire empty_transmit_error,
  input wire integrity_error,

  // Low-power card detection and timers.
  input wire card_found,
  input wire [4:0] timer_underflow,

  // Interrupt pin.
  output wire irq_pin_out,
  output wire irq_pin_oe_b,
  output wire combined_request_flag
);

  // ********************************************************************
  // Declarations
  // ********************************************************************
  reg [7:0] enable_low_r;
  reg [7:0] enable_high_r;
  reg [7:0] rdata_r;
  reg hit_r;
  reg force_idle_r;
  reg [7:0] rdata_nxt;
  reg hit_nxt;

  wire [9:0] fifo_size;
  wire [9:0] free_space;
  wire [9:0] water_eff;
  wire fifo_high_level_live;
  wire fifo_low_level_live;
  wire cmd_unknown;
  wire cmd_done_evt;
  wire err_any;
  wire [6:0] low_evt;
  wire [5:0] high_evt;
  wire [6:0] flags_low;
  wire [5:0] flags_high;
  wire wr_low;
  wire wr_high;
  wire wr_en_low;
  wire wr_en_high;
  wire combined;
  wire fifo_high_level_flag;
  wire fifo_low_level_flag;
  wire command_done_flag;
  wire transmit_done_flag;
  wire receive_done_flag;
  wire error_summary_flag;
  wire frame_start_flag;
  wire card_presence_flag;
  wire timer_e_underflow_flag;
  wire timer_d_underflow_flag;
  wire timer_c_underflow_flag;
  wire timer_b_underflow_flag;
  wire timer_a_underflow_flag;
  wire fifo_high_level_enable;
  wire fifo_low_level_enable;
  wire command_done_enable;
  wire transmit_done_enable;
  wire receive_done_enable;
  wire error_summary_enable;
  wire frame_start_enable;
  wire card_presence_enable;
  wire timer_e_underflow_enable;
  wire timer_d_underflow_enable;
  wire timer_c_underflow_enable;
  wire timer_b_underflow_enable;
  wire timer_a_underflow_enable;
  wire pin_invert;
  wire pin_request_enable;
  wire pin_drive_push_pull;

  // ********************************************************************
  // FIFO level status
  // ********************************************************************
  assign fifo_size = fifo_size_small ? `FIFO_SIZE_SMALL : `FIFO_SIZE_LARGE;

  // The water level extension bit only counts in the large FIFO mode.
  assign water_eff = fifo_size_small ? {2'b00, water_level[7:0]} :
                                       {1'b0, water_level};

  assign free_space = fifo_size - fifo_length;

  assign fifo_high_level_live = (free_space <= water_eff);

  assign fifo_low_level_live = (fifo_length <= water_eff);

  // ********************************************************************
  // Command completion
  // ********************************************************************
  // Codes outside the known set cannot run and fall straight back to idle.
  assign cmd_unknown = command_start & ~CMD_KNOWN_MASK[command_start_code];

  assign cmd_done_evt = command_finished | cmd_unknown;

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      force_idle_r <= 1'b0;
    end else begin
      force_idle_r <= cmd_unknown;
    end
  end

  assign command_force_idle = force_idle_r;

  // ********************************************************************
  // Error summary
  // ********************************************************************
  // any listed error
  assign err_any = fifo_write_violation |
                   fifo_overflow_error |
                   protocol_error |
                   empty_transmit_error |
                   integrity_error;

  // ********************************************************************
  // Event vectors
  // ********************************************************************
  // fifo high latch
  assign low_evt[`FIFO_HIGH_BIT] = fifo_high_level_live;
  assign low_evt[`FIFO_LOW_BIT] = fifo_low_level_live;
  assign low_evt[`CMD_DONE_BIT] = cmd_done_evt;
  assign low_evt[`TX_DONE_BIT] = transmit_last_bit;
  assign low_evt[`RX_DONE_BIT] = receive_end;
  assign low_evt[`ERR_SUM_BIT] = err_any;
  assign low_evt[`FRAME_START_BIT] = frame_start_seen;

  assign high_evt[`CARD_BIT] = card_found;
  assign high_evt[4:0] = timer_underflow;

  // ********************************************************************
  // Write decode
  // ********************************************************************
  assign wr_low = reg_wr_en && (reg_addr == `FLAGS_LOW_ADDR);
  assign wr_high = reg_wr_en && (reg_addr == `FLAGS_HIGH_ADDR);
  assign wr_en_low = reg_wr_en && (reg_addr == `ENABLE_LOW_ADDR);
  assign wr_en_high = reg_wr_en && (reg_addr == `ENABLE_HIGH_ADDR);

  // ********************************************************************
  // Flag banks
  // ********************************************************************
  // low flag bank
  flag_bank #(
    .WIDTH(`FLAG_LOW_W),
    .RESET_VAL(`FLAGS_LOW_RESET)
  ) u_flags_low (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .evt_level(low_evt),
    .wr_stb(wr_low),
    .wr_set(reg_wdata[`SET_BIT]),
    .wr_mask(reg_wdata[`FLAG_LOW_W-1:0]),
    .flags(flags_low)
  );

  flag_bank #(
    .WIDTH(`FLAG_HIGH_W),
    .RESET_VAL(`FLAGS_HIGH_RESET)
  ) u_flags_high (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .evt_level(high_evt),
    .wr_stb(wr_high),
    .wr_set(reg_wdata[`SET_BIT]),
    .wr_mask(reg_wdata[`FLAG_HIGH_W-1:0]),
    .flags(flags_high)
  );

  // ********************************************************************
  // Enable registers
  // ********************************************************************
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      enable_low_r <= `ENABLE_RESET;
      enable_high_r <= `ENABLE_RESET;
    end else begin
      if (wr_en_low) begin
        enable_low_r <= reg_wdata;
      end
      if (wr_en_high) begin
        enable_high_r <= reg_wdata;
      end
    end
  end

  // ********************************************************************
  // Named flag and enable fields
  // ********************************************************************
  assign fifo_high_level_flag = flags_low[`FIFO_HIGH_BIT];
  assign fifo_low_level_flag = flags_low[`FIFO_LOW_BIT];
  assign command_done_flag = flags_low[`CMD_DONE_BIT];
  assign transmit_done_flag = flags_low[`TX_DONE_BIT];
  assign receive_done_flag = flags_low[`RX_DONE_BIT];
  assign error_summary_flag = flags_low[`ERR_SUM_BIT];
  assign frame_start_flag = flags_low[`FRAME_START_BIT];
  assign card_presence_flag = flags_high[`CARD_BIT];
  assign timer_e_underflow_flag = flags_high[`TIMER_E_BIT];
  assign timer_d_underflow_flag = flags_high[`TIMER_D_BIT];
  assign timer_c_underflow_flag = flags_high[`TIMER_C_BIT];
  assign timer_b_underflow_flag = flags_high[`TIMER_B_BIT];
  assign timer_a_underflow_flag = flags_high[`TIMER_A_BIT];

  assign fifo_high_level_enable = enable_low_r[`FIFO_HIGH_BIT];
  assign fifo_low_level_enable = enable_low_r[`FIFO_LOW_BIT];
  assign command_done_enable = enable_low_r[`CMD_DONE_BIT];
  assign transmit_done_enable = enable_low_r[`TX_DONE_BIT];
  assign receive_done_enable = enable_low_r[`RX_DONE_BIT];
  assign error_summary_enable = enable_low_r[`ERR_SUM_BIT];
  assign frame_start_enable = enable_low_r[`FRAME_START_BIT];

  assign card_presence_enable = enable_high_r[`CARD_BIT];
  assign timer_e_underflow_enable = enable_high_r[`TIMER_E_BIT];
  assign timer_d_underflow_enable = enable_high_r[`TIMER_D_BIT];
  assign timer_c_underflow_enable = enable_high_r[`TIMER_C_BIT];
  assign timer_b_underflow_enable = enable_high_r[`TIMER_B_BIT];
  assign timer_a_underflow_enable = enable_high_r[`TIMER_A_BIT];

  assign pin_invert = enable_low_r[`PIN_INVERT_BIT];
  assign pin_request_enable = enable_high_r[`PIN_ENABLE_BIT];
  assign pin_drive_push_pull = enable_high_r[`PUSH_PULL_BIT];

  // ********************************************************************
  // Combined request
  // ********************************************************************
  // Kept combinational so it drops in the same cycle as the last enabled flag.
  // enabled OR
  assign combined = (fifo_high_level_flag & fifo_high_level_enable) |
                    (fifo_low_level_flag & fifo_low_level_enable) |
                    (command_done_flag & command_done_enable) |
                    (transmit_done_flag & transmit_done_enable) |
                    (receive_done_flag & receive_done_enable) |
                    (error_summary_flag & error_summary_enable) |
                    (frame_start_flag & frame_start_enable) |
                    (card_presence_flag & card_presence_enable) |
                    (timer_e_underflow_flag & timer_e_underflow_enable) |
                    (timer_d_underflow_flag & timer_d_underflow_enable) |
                    (timer_c_underflow_flag & timer_c_underflow_enable) |
                    (timer_b_underflow_flag & timer_b_underflow_enable) |
                    (timer_a_underflow_flag & timer_a_underflow_enable);

  assign combined_request_flag = combined;

  // ********************************************************************
  // Interrupt pin
  // ********************************************************************
  irq_pin_driver u_pin (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .request(combined),
    .pin_request_enable(pin_request_enable),
    .pin_invert(pin_invert),
    .pin_drive_push_pull(pin_drive_push_pull),
    .irq_pin_out(irq_pin_out),
    .irq_pin_oe_b(irq_pin_oe_b)
  );

  // ********************************************************************
  // Read path
  // ********************************************************************
  always @* begin
    rdata_nxt = `READ_ZERO;
    hit_nxt = 1'b1;
    case (reg_addr)
      `FLAGS_LOW_ADDR: begin
        rdata_nxt = {1'b0, flags_low};
      end
      `FLAGS_HIGH_ADDR: begin
        rdata_nxt = {1'b0, combined, flags_high};
      end
      `ENABLE_LOW_ADDR: begin
        rdata_nxt = enable_low_r;
      end
      `ENABLE_HIGH_ADDR: begin
        rdata_nxt = enable_high_r;
      end
      default: begin
        rdata_nxt = `READ_ZERO;
        hit_nxt = 1'b0;
      end
    endcase
  end

  // Read data is registered so the host interface sees a stable byte.
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      rdata_r <= `READ_ZERO;
      hit_r <= 1'b0;
    end else if (reg_rd_en) begin
      rdata_r <= rdata_nxt;
      hit_r <= hit_nxt;
    end else begin
      hit_r <= 1'b0;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_hit = hit_r;

endmodule // reader_interrupt_request_unit

/* test/irq_unit_chk.sv */
// Port assertions for the interrupt request unit.
`timescale 1ns/1ns
module irq_unit_chk #(
  parameter [31:0] CMD_KNOWN_MASK = 32'h00FF_FFFF
) (
  input wire clk_sys,
  input wire rst_b,
  input wire [7:0] reg_addr,
  input wire reg_wr_en,
  input wire [7:0] reg_wdata,
  input wire reg_rd_en,
  input wire [7:0] reg_rdata,
  input wire reg_hit,
  input wire command_start,
  input wire [4:0] command_start_code,
  input wire command_force_idle,
  input wire card_found,
  input wire [4:0] timer_underflow,
  input wire irq_pin_out,
  input wire irq_pin_oe_b,
  input wire combined_request_flag
);
  // ********************************************************************
  // Shadow of the enable registers from observed writes, previous card and timer events, unknown starts
  // ********************************************************************
  logic [7:0] en_lo_r;
  logic [7:0] en_hi_r;
  logic [5:0] hi_prev_r;
  logic unk_r;
  wire mapped = reg_addr >= 8'h06 && reg_addr <= 8'h09;
  wire lvl = (combined_request_flag & en_hi_r[6]) ^ en_lo_r[7];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      en_lo_r <= 8'h00;
      en_hi_r <= 8'h00;
      hi_prev_r <= 6'h00;
      unk_r <= 1'b0;
    end else begin
      hi_prev_r <= {card_found, timer_underflow};
      unk_r <= command_start && !CMD_KNOWN_MASK[command_start_code];
      if (reg_wr_en && reg_addr == 8'h08) en_lo_r <= reg_wdata;
      if (reg_wr_en && reg_addr == 8'h09) en_hi_r <= reg_wdata;
    end
  end
  a_read_hit_map: assert property (reg_rd_en && mapped |=> reg_hit)
    else $error("mapped read gave no hit");
  a_unmapped_zero: assert property (reg_rd_en && !mapped |=>
    !reg_hit && reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_bit7_zero: assert property (reg_rd_en && reg_addr[7:1] == 7'h03 |=>
    !reg_rdata[7]) else $error("flag bit 7 read back as one");
  a_combined_read: assert property (reg_rd_en && reg_addr == 8'h07 |=>
    reg_rdata[6] == $past(combined_request_flag)) else $error("combined bit read wrong");
  a_force_idle_cause: assert property (command_force_idle == unk_r)
    else $error("force idle without unknown start");
  a_pin_drive_mode: assert property (1'b1 |=>
    irq_pin_oe_b == ($past(en_hi_r[7]) ? 1'b0 : $past(lvl))) else $error("pin enable wrong");
  a_pin_level_out: assert property (1'b1 |=>
    irq_pin_out == ($past(en_hi_r[7]) & $past(lvl))) else $error("pin level wrong");
  a_hi_event_req: assert property (!reg_wr_en &&
    |({card_found, timer_underflow} & ~hi_prev_r & en_hi_r[5:0]) |=> combined_request_flag)
    else $error("enabled event gave no request");
  a_disabled_quiet: assert property (en_lo_r[6:0] == 7'h00 && en_hi_r[5:0] == 6'h00
    |-> !combined_request_flag) else $error("request with all enables off");
  a_set_raises: assert property (reg_wr_en && reg_addr == 8'h06 && reg_wdata[7] &&
    |(reg_wdata[6:0] & en_lo_r[6:0]) |=> combined_request_flag) else $error("set gave no request");
  c_force_idle: cover property (command_force_idle);
  c_push_pull: cover property (en_hi_r[7] && lvl);
  c_hit_read: cover property (reg_hit);
endmodule // irq_unit_chk

bind reader_interrupt_request_unit irq_unit_chk #(.CMD_KNOWN_MASK(CMD_KNOWN_MASK)) chk_u (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
  .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
  .command_start(command_start), .command_start_code(command_start_code),
  .command_force_idle(command_force_idle), .card_found(card_found),
  .timer_underflow(timer_underflow), .irq_pin_out(irq_pin_out), .irq_pin_oe_b(irq_pin_oe_b),
  .combined_request_flag(combined_request_flag));

/* test/host_model.sv */
// Host controller model that drives the register port.
`timescale 1ns/1ns
module host_model (
  input wire clk_sys,
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wdata,
  output logic reg_rd_en,
  input wire [7:0] reg_rdata,
  input wire reg_hit
);
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
  end
  // Released lines show the inverse so a stale value is never mistaken for a live one.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge clk_sys);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
    h = reg_hit;
  endtask
endmodule // host_model

/* test/testbench.sv */
// Self-checking bench of the interrupt request unit.
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module testbench;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] lo_ev = 5'h00;
  logic [4:0] errs = 5'h00;
  logic [5:0] hi_ev = 6'h00;
  logic [9:0] fifo_length = 10'h080;
  logic [8:0] water_level = 9'h000;
  logic fifo_size_small = 1'b0;
  logic command_start = 1'b0;
  logic [4:0] command_start_code = 5'h00;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr_en, reg_rd_en, reg_hit, command_force_idle;
  wire irq_pin_out, irq_pin_oe_b, combined_request_flag;
  int errors = 0;
  int checks = 0;
  int g, b;
  logic [7:0] a, v, fl, fh, el, eh;
  logic [6:0] ex [2];
  logic cm;
  always #5 clk_sys = ~clk_sys;
  host_model hm_u (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .reg_hit(reg_hit));
  reader_interrupt_request_unit dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .fifo_size_small(fifo_size_small),
    .fifo_length(fifo_length), .water_level(water_level), .command_finished(lo_ev[4]),
    .command_start(command_start), .command_start_code(command_start_code),
    .command_force_idle(command_force_idle), .transmit_last_bit(lo_ev[3]),
    .receive_end(lo_ev[2]), .frame_start_seen(lo_ev[0]), .fifo_write_violation(errs[0]),
    .fifo_overflow_error(errs[1]), .protocol_error(errs[2]), .empty_transmit_error(errs[3]),
    .integrity_error(errs[4]), .card_found(hi_ev[5]), .timer_underflow(hi_ev[4:0]),
    .irq_pin_out(irq_pin_out), .irq_pin_oe_b(irq_pin_oe_b),
    .combined_request_flag(combined_request_flag));
  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic [1:0] pin_exp(input logic c, input logic inv, input logic [7:0] e);
    logic lv;
    lv = (c & e[6]) ^ inv;
    return e[7] ? {lv, 1'b0} : {1'b0, lv};
  endfunction
  task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
    logic [7:0] d;
    logic h;
    hm_u.rd(ad, d, h);
    `CHK(d, e)
    `CHK(h, (ad >= 8'h06 && ad <= 8'h09))
  endtask
  task automatic pulse(input int gr, input int k);
    @(posedge clk_sys);
    case (gr)
      0: lo_ev[k] <= 1'b1;
      1: errs[k] <= 1'b1;
      default: hi_ev[k] <= 1'b1;
    endcase
    @(posedge clk_sys);
    lo_ev <= 5'h00;
    errs <= 5'h00;
    hi_ev <= 6'h00;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic cmd(input logic [4:0] c, input logic e);
    @(posedge clk_sys);
    command_start <= 1'b1;
    command_start_code <= c;
    @(posedge clk_sys);
    command_start <= 1'b0;
    #1;
    `CHK(command_force_idle, e)
    rdc(8'h06, {3'b000, e, 4'h0});
    hm_u.wr(8'h06, 8'h7F);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    give_verdict;
  end
  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    void'($urandom(32'h351E));
    ex[0] = 7'h00;
    ex[1] = 7'h00;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdc(8'h06, 8'h00);
    rdc(8'h07, 8'h00);
    rdc(8'h0A, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      b = i % 2;
      a = 8'h06 + b[7:0];
      v = $urandom;
      v[7] = i[1];
      hm_u.wr(a, v);
      ex[b] = (v[7] ? ex[b] | v[6:0] : ex[b] & ~v[6:0]) & (b ? 7'h3F : 7'h7F);
      rdc(a, {1'b0, ex[b]});
    end
    hm_u.wr(8'h06, 8'h7F);
    hm_u.wr(8'h07, 8'h3F);
    $display("test set clear done");
    // Card and timer events are enabled so they also raise the combined bit.
    hm_u.wr(8'h09, 8'h3F);
    for (int k = 0; k < 16; k++) begin
      if (k == 1) continue;
      g = (k < 5) ? 0 : (k < 10) ? 1 : 2;
      b = (g == 0) ? k : (g == 1) ? 1 : k - 10;
      pulse(g, (g == 1) ? k - 5 : b);
      a = (g == 2) ? 8'h07 : 8'h06;
      v = (g == 2) ? 8'h40 : 8'h00;
      rdc(a, v | (8'h01 << b));
      hm_u.wr(a, 8'h7F);
    end
    @(posedge clk_sys);
    fifo_length <= 10'h200;
    rdc(8'h06, 8'h40);
    hm_u.wr(8'h06, 8'h7F);
    fifo_length <= 10'h000;
    rdc(8'h06, 8'h20);
    hm_u.wr(8'h06, 8'h7F);
    // Small FIFO ignores water level bit 8, so only the high-level flag may rise.
    fifo_size_small <= 1'b1;
    water_level <= 9'h110;
    fifo_length <= 10'h0F0;
    rdc(8'h06, 8'h40);
    hm_u.wr(8'h06, 8'h7F);
    fifo_size_small <= 1'b0;
    water_level <= 9'h000;
    fifo_length <= 10'h080;
    $display("test events done");
    cmd(5'h18, 1'b1);
    cmd(5'h00, 1'b0);
    $display("test command done");
    for (int i = 0; i < 24; i++) begin
      fl = $urandom;
      fh = $urandom;
      el = $urandom;
      eh = $urandom;
      hm_u.wr(8'h06, {1'b1, fl[6:0]});
      hm_u.wr(8'h07, {1'b1, fh[6:0]});
      hm_u.wr(8'h08, el);
      hm_u.wr(8'h09, eh);
      repeat (2) @(posedge clk_sys);
      #1;
      cm = |(fl[6:0] & el[6:0]) | |(fh[5:0] & eh[5:0]);
      `CHK(combined_request_flag, cm)
      `CHK({irq_pin_out, irq_pin_oe_b}, pin_exp(cm, el[7], eh))
      rdc(8'h07, {1'b0, cm, fh[5:0]});
      rdc(8'h09, eh);
      hm_u.wr(8'h06, 8'h7F);
      hm_u.wr(8'h07, 8'h3F);
      #1;
      `CHK(combined_request_flag, 1'b0)
    end
    $display("test combined pin done");
    hm_u.wr(8'h06, 8'hFF);
    hm_u.wr(8'h08, 8'h7F);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdc(8'h06, 8'h00);
    rdc(8'h08, 8'h00);
    `CHK(combined_request_flag, 1'b0)
    $display("test reset again done");
    give_verdict;
  end
endmodule // testbench
